/* hw/rcsl_pkg.sv */
// package for the reset-cause status logic: constants, encodings and carriers
package rcsl_pkg;

  // program counter and vector values
  localparam int          PC_W          = 21;
  localparam logic [20:0] PC_RESET      = 21'h000000;
  localparam logic [20:0] VEC_HIGH      = 21'h000008;
  localparam logic [20:0] VEC_LOW       = 21'h000018;
  localparam logic [20:0] PC_WAKE_STEP  = 21'h000002;

  // brown-out configuration value that enables the software switch
  localparam logic [1:0]  BOR_CFG_SOFT  = 2'h1;

  // register map of the plain register port
  localparam logic [3:0]  ADDR_RESET_CONTROL_REG     = 4'h0;
  localparam logic [3:0]  ADDR_STACK    = 4'h1;
  localparam logic [3:0]  ADDR_PC_LO    = 4'h2;
  localparam logic [3:0]  ADDR_PC_MID   = 4'h3;
  localparam logic [3:0]  ADDR_PC_HI    = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0]  ADDR_GP       = 4'h7;

  // bit positions inside the reset control register
  localparam int RC_SOFT_BROWNOUT_ENABLE = 6;
  localparam int RC_RI     = 4;
  localparam int RC_TO     = 3;
  localparam int RC_PD     = 2;
  localparam int RC_POR    = 1;
  localparam int RC_BOR    = 0;
  // bit positions inside the stack register
  localparam int SK_FUL    = 7;
  localparam int SK_UNF    = 6;

  // reset values of the flags after power-on
  localparam logic [7:0] RESET_CONTROL_REG_POR_VAL  = 8'h5c;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  localparam int         N_EVT         = 8;

  // reset and wake-up causes; priority is set by the cause selection in rcsl_reset_cause, not by this order
  typedef enum {
    RCSL_C_NONE,
    RCSL_C_POR,
    RCSL_C_BOR,
    RCSL_C_RESET_INSTR,
    RCSL_C_MASTER_CLEAR_PIN_RUN,
    RCSL_C_MASTER_CLEAR_PIN_IDLE,
    RCSL_C_WDT_RUN,
    RCSL_C_MASTER_CLEAR_PIN_FULL,
    RCSL_C_STK_FULL,
    RCSL_C_STK_UNF,
    RCSL_C_WDT_WAKE,
    RCSL_C_INT_WAKE
  } rcsl_cause_e;

  // power state of the core
  typedef enum {
    RCSL_P_FULL,
    RCSL_P_RUN,
    RCSL_P_IDLE,
    RCSL_P_SLEEP
  } rcsl_pwr_e;

  // reset and wake-up sources sampled each cycle
  typedef struct packed {
    logic por;
    logic bor;
    logic reset_instr;
    logic master_clear_pin;
    logic watchdog_timer;
    logic stack_overflow;
    logic stack_underflow;
    logic int_wake;
  } rcsl_src_s;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcsl_req_s;

endpackage : rcsl_pkg

/* hw/rcsl_reset_cause.sv */
// reset-cause recording: program counter load, status flags and event interrupt
`timescale 1ns/10ps
module rcsl_reset_cause #(
  parameter int PCW = rcsl_pkg::PC_W
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire rcsl_pkg::rcsl_src_s src,
  input  wire logic [1:0]          pwr_state,
  input  wire logic [1:0]          brownout_mode_config,
  input  wire logic                stack_fault_reset_enable,
  input  wire logic                global_int_enable_high,
  input  wire logic                global_int_enable_low,
  input  wire logic                int_is_high,
  input  wire logic [PCW-1:0]      pc_now,
  input  wire rcsl_pkg::rcsl_req_s req,
  output logic [7:0]               rdata,
  output logic                     core_reset,
  output logic                     pc_load,
  output logic [PCW-1:0]           pc_value,
  output logic [7:0]               reset_control_reg,
  output logic [7:0]               stack_pointer_reg,
  output logic                     irq
);

  rcsl_pkg::rcsl_cause_e cause;
  rcsl_pkg::rcsl_pwr_e   pwr;
  logic [7:0]            rc_r;
  logic [7:0]            rc_nxt;
  logic [7:0]            sk_r;
  logic [7:0]            sk_nxt;
  logic [7:0]            gp_r;
  logic [7:0]            stat_r;
  logic [7:0]            mask_r;
  logic [7:0]            evt;
  logic                  soft_ok;
  logic                  wr_rc;
  logic                  wr_sk;

  // decode of the power state input
  always_comb
  begin
    case (pwr_state)
      2'h0:    pwr = rcsl_pkg::RCSL_P_FULL;
      2'h1:    pwr = rcsl_pkg::RCSL_P_RUN;
      2'h2:    pwr = rcsl_pkg::RCSL_P_IDLE;
      default: pwr = rcsl_pkg::RCSL_P_SLEEP;
    endcase
  end

  // soft brown-out switch only when configuration allows it
  assign soft_ok = (brownout_mode_config == rcsl_pkg::BOR_CFG_SOFT);

  // pick the single cause to apply this cycle, highest first
  always_comb
  begin
    cause = rcsl_pkg::RCSL_C_NONE;
    if (src.por)
      cause = rcsl_pkg::RCSL_C_POR;
    else if (src.bor)
      cause = rcsl_pkg::RCSL_C_BOR;
    else if (src.reset_instr)
      cause = rcsl_pkg::RCSL_C_RESET_INSTR;
    else if (src.master_clear_pin && pwr == rcsl_pkg::RCSL_P_RUN)
      cause = rcsl_pkg::RCSL_C_MASTER_CLEAR_PIN_RUN;
    else if (src.master_clear_pin && (pwr == rcsl_pkg::RCSL_P_IDLE ||
             pwr == rcsl_pkg::RCSL_P_SLEEP))
      cause = rcsl_pkg::RCSL_C_MASTER_CLEAR_PIN_IDLE;
    else if (src.master_clear_pin)
      cause = rcsl_pkg::RCSL_C_MASTER_CLEAR_PIN_FULL;
    else if (src.watchdog_timer && (pwr == rcsl_pkg::RCSL_P_FULL ||
             pwr == rcsl_pkg::RCSL_P_RUN))
      cause = rcsl_pkg::RCSL_C_WDT_RUN;
    else if (src.watchdog_timer)
      cause = rcsl_pkg::RCSL_C_WDT_WAKE;
    else if (src.stack_overflow && stack_fault_reset_enable)
      cause = rcsl_pkg::RCSL_C_STK_FULL;
    else if (src.stack_underflow)
      cause = rcsl_pkg::RCSL_C_STK_UNF;
    else if (src.int_wake && pwr != rcsl_pkg::RCSL_P_FULL)
      cause = rcsl_pkg::RCSL_C_INT_WAKE;
  end

  // register port write decode
  assign wr_rc = req.wr && req.addr == rcsl_pkg::ADDR_RESET_CONTROL_REG;
  assign wr_sk = req.wr && req.addr == rcsl_pkg::ADDR_STACK;

  // next value of the reset control flags
  always_comb
  begin
    rc_nxt = rc_r;
    if (wr_rc)
      rc_nxt = req.wdata;
    case (cause)
      rcsl_pkg::RCSL_C_POR:
      begin
        rc_nxt = rcsl_pkg::RESET_CONTROL_REG_POR_VAL;
        rc_nxt[rcsl_pkg::RC_SOFT_BROWNOUT_ENABLE] = soft_ok;
      end
      rcsl_pkg::RCSL_C_BOR:
      begin
        rc_nxt[rcsl_pkg::RC_RI]  = 1'b1;
        rc_nxt[rcsl_pkg::RC_TO]  = 1'b1;
        rc_nxt[rcsl_pkg::RC_PD]  = 1'b1;
        rc_nxt[rcsl_pkg::RC_BOR] = 1'b0;
      end
      rcsl_pkg::RCSL_C_RESET_INSTR:
        rc_nxt[rcsl_pkg::RC_RI] = 1'b0;
      rcsl_pkg::RCSL_C_MASTER_CLEAR_PIN_RUN:
        rc_nxt[rcsl_pkg::RC_TO] = 1'b1;
      rcsl_pkg::RCSL_C_MASTER_CLEAR_PIN_IDLE:
      begin
        rc_nxt[rcsl_pkg::RC_TO] = 1'b1;
        rc_nxt[rcsl_pkg::RC_PD] = 1'b0;
      end
      rcsl_pkg::RCSL_C_WDT_RUN:
        rc_nxt[rcsl_pkg::RC_TO] = 1'b0;
      rcsl_pkg::RCSL_C_WDT_WAKE:
      begin
        rc_nxt[rcsl_pkg::RC_TO] = 1'b0;
        rc_nxt[rcsl_pkg::RC_PD] = 1'b0;
      end
      rcsl_pkg::RCSL_C_INT_WAKE:
        rc_nxt[rcsl_pkg::RC_PD] = 1'b0;
      default:
        rc_nxt = rc_nxt;
    endcase
    // soft enable kept on non-power-on resets, zero when not allowed
    if (!soft_ok)
      rc_nxt[rcsl_pkg::RC_SOFT_BROWNOUT_ENABLE] = 1'b0;
    rc_nxt[7] = 1'b0;
    rc_nxt[5] = 1'b0;
  end

  // next value of the stack flags
  always_comb
  begin
    sk_nxt = sk_r;
    if (wr_sk)
      sk_nxt = req.wdata;
    if (cause == rcsl_pkg::RCSL_C_POR)
      sk_nxt = 8'h00;
    else if (cause == rcsl_pkg::RCSL_C_STK_FULL)
      sk_nxt[rcsl_pkg::SK_FUL] = 1'b1;
    else if (cause == rcsl_pkg::RCSL_C_STK_UNF)
      sk_nxt[rcsl_pkg::SK_UNF] = 1'b1;
    sk_nxt[5:0] = 6'h00;
  end

  // flag registers take their defined state at power-on
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc_r <= rcsl_pkg::RESET_CONTROL_REG_POR_VAL;
      sk_r <= 8'h00;
    end
    else if (clk_en)
    begin
      rc_r <= rc_nxt;
      sk_r <= sk_nxt;
    end
  end

  // general register with no reset state: only software changes it
  always_ff @(posedge clk)
  begin
    if (clk_en && req.wr && req.addr == rcsl_pkg::ADDR_GP)
      gp_r <= req.wdata;
  end

  // program counter load and core reset request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reset <= 1'b1;
      pc_load    <= 1'b1;
      pc_value   <= rcsl_pkg::PC_RESET[PCW-1:0];
    end
    else if (clk_en)
    begin
      core_reset <= 1'b0;
      pc_load    <= 1'b0;
      case (cause)
        rcsl_pkg::RCSL_C_NONE:
          pc_value <= pc_value;
        rcsl_pkg::RCSL_C_STK_UNF:
        begin
          // underflow without the enable only raises the flag
          if (stack_fault_reset_enable)
          begin
            core_reset <= 1'b1;
            pc_load    <= 1'b1;
            pc_value   <= rcsl_pkg::PC_RESET[PCW-1:0];
          end
        end
        rcsl_pkg::RCSL_C_WDT_WAKE:
        begin
          pc_load  <= 1'b1;
          pc_value <= pc_now + rcsl_pkg::PC_WAKE_STEP[PCW-1:0];
        end
        rcsl_pkg::RCSL_C_INT_WAKE:
        begin
          pc_load <= 1'b1;
          if (int_is_high && global_int_enable_high)
            pc_value <= rcsl_pkg::VEC_HIGH[PCW-1:0];
          else if (!int_is_high && global_int_enable_low)
            pc_value <= rcsl_pkg::VEC_LOW[PCW-1:0];
          else
            pc_value <= pc_now + rcsl_pkg::PC_WAKE_STEP[PCW-1:0];
        end
        default:
        begin
          core_reset <= 1'b1;
          pc_load    <= 1'b1;
          pc_value   <= rcsl_pkg::PC_RESET[PCW-1:0];
        end
      endcase
    end
  end

  // one event bit per source, sticky status cleared by writing one
  assign evt = src;
  generate
    for (genvar i = 0; i < rcsl_pkg::N_EVT; i++)
    begin : g_evt
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          stat_r[i] <= 1'b0;
        else if (clk_en)
        begin
          if (evt[i])
            stat_r[i] <= 1'b1;                            // set beats clear
          else if (req.wr && req.addr == rcsl_pkg::ADDR_IRQ_STAT && req.wdata[i])
            stat_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt mask register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mask_r <= rcsl_pkg::IRQ_MASK_RST;
    else if (clk_en && req.wr && req.addr == rcsl_pkg::ADDR_IRQ_MASK)
      mask_r <= req.wdata;
  end

  // interrupt output and visible copies of the flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq               <= 1'b0;
      reset_control_reg <= rcsl_pkg::RESET_CONTROL_REG_POR_VAL;
      stack_pointer_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      irq               <= |(stat_r & mask_r);
      reset_control_reg <= rc_r;
      stack_pointer_reg <= sk_r;
    end
  end

  // read data one cycle after the read strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (clk_en)
    begin
      if (req.rd)
      begin
        case (req.addr)
          rcsl_pkg::ADDR_RESET_CONTROL_REG:     rdata <= soft_ok ? rc_r : (rc_r & 8'hbf);
          rcsl_pkg::ADDR_STACK:    rdata <= sk_r;
          rcsl_pkg::ADDR_PC_LO:    rdata <= 8'(pc_value);
          rcsl_pkg::ADDR_PC_MID:   rdata <= 8'(pc_value >> 8);
          rcsl_pkg::ADDR_PC_HI:    rdata <= 8'(pc_value >> 16);
          rcsl_pkg::ADDR_IRQ_STAT: rdata <= stat_r;
          rcsl_pkg::ADDR_IRQ_MASK: rdata <= mask_r;
          rcsl_pkg::ADDR_GP:       rdata <= gp_r;
          default:                 rdata <= 8'h00;
        endcase
      end
      else
        rdata <= 8'h00;
    end
  end

endmodule : rcsl_reset_cause

/* verification/rcsl_reset_cause_monitor.sv */
// checker for the reset-cause status logic
`timescale 1ns/10ps
module rcsl_reset_cause_monitor #(
  parameter int PCW = 21
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                clk_en,
  input wire rcsl_pkg::rcsl_src_s src,
  input wire logic [1:0]          pwr_state,
  input wire logic [1:0]          brownout_mode_config,
  input wire logic                stack_fault_reset_enable,
  input wire logic                global_int_enable_high,
  input wire logic                global_int_enable_low,
  input wire logic [PCW-1:0]      pc_now,
  input wire logic                core_reset,
  input wire logic                pc_load,
  input wire logic [PCW-1:0]      pc_value,
  input wire logic [7:0]          reset_control_reg,
  input wire logic [7:0]          stack_pointer_reg,
  input wire logic                irq
);
  logic [7:0] s;
  logic       gie_off;

  // flat view of the sources
  assign s       = src;
  assign gie_off = !global_int_enable_high && !global_int_enable_low;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  por_restart_a:
  assert property (clk_en && s[7] |=> core_reset && pc_value == '0
    ##1 reset_control_reg[4:0] == 5'h1c && stack_pointer_reg == 8'h00) else $error("por flags");
  bor_flags_a:
  assert property (clk_en && s[7:6] == 2'h1 |=> pc_value == '0
    ##1 reset_control_reg[4:2] == 3'h7 && !reset_control_reg[0]) else $error("bor flags");
  ri_clear_a:
  assert property (clk_en && s[7:5] == 3'h1 |=> core_reset ##1 !reset_control_reg[4])
    else $error("ri flag");
  wdt_run_a:
  assert property (clk_en && s == 8'h08 && pwr_state < 2 |=> core_reset && pc_value == '0
    ##1 !reset_control_reg[3]) else $error("wdt run");
  master_clear_pin_idle_a:
  assert property (clk_en && s == 8'h10 && pwr_state >= 2 |=> core_reset
    ##1 reset_control_reg[3:2] == 2'h2) else $error("master_clear_pin idle");
  stk_full_a:
  assert property (clk_en && s == 8'h04 && stack_fault_reset_enable |=> core_reset
    ##1 stack_pointer_reg[7]) else $error("stack full");
  unf_soft_a:
  assert property (clk_en && s == 8'h02 && !stack_fault_reset_enable |=> !core_reset && !pc_load
    ##1 stack_pointer_reg[6]) else $error("underflow");
  wake_pc_a:
  assert property (clk_en && s inside {8'h01, 8'h08} && pwr_state >= 2 && gie_off
    |=> pc_load && !core_reset && pc_value == $past(pc_now) + 2'd2) else $error("wake pc");
  sbo_cfg_a:
  assert property ((clk_en && brownout_mode_config != 2'h1) [*2] |=> !reset_control_reg[6])
    else $error("soft enable");

  c_wake: cover property (s == 8'h01 && global_int_enable_high ##1 pc_load);
  c_irq: cover property ($rose(irq));
  c_unf: cover property (s == 8'h02 && !stack_fault_reset_enable);
endmodule : rcsl_reset_cause_monitor

bind rcsl_reset_cause rcsl_reset_cause_monitor #(.PCW(PCW)) u_mon (
  .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .src(src), .pwr_state(pwr_state),
  .brownout_mode_config(brownout_mode_config),
  .stack_fault_reset_enable(stack_fault_reset_enable),
  .global_int_enable_high(global_int_enable_high),
  .global_int_enable_low(global_int_enable_low), .pc_now(pc_now),
  .core_reset(core_reset), .pc_load(pc_load), .pc_value(pc_value),
  .reset_control_reg(reset_control_reg), .stack_pointer_reg(stack_pointer_reg), .irq(irq)
);

/* verification/rcsl_reset_cause_tb_top.sv */
// self-checking testbench for the reset-cause status logic
`timescale 1ns/10ps
module rcsl_reset_cause_tb_top;
  logic        clk = 0, rst_n = 0, sfe = 1, gh = 0, gl = 0, hi = 0;
  logic [1:0]  pw = 0, cfg = 2'h1;
  logic [7:0]  src = 0, rdata, rc, sk;
  logic [13:0] req = 0;
  logic [20:0] pc_now = 0, pc_value;
  logic        core_reset, pc_load, irq;
  int          errors = 0, samples_checked = 0;

  // free-running clock
  always #5 clk = ~clk;

  rcsl_reset_cause dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .src(src), .pwr_state(pw),
    .brownout_mode_config(cfg), .stack_fault_reset_enable(sfe),
    .global_int_enable_high(gh), .global_int_enable_low(gl), .int_is_high(hi),
    .pc_now(pc_now), .req(req), .rdata(rdata), .core_reset(core_reset), .pc_load(pc_load),
    .pc_value(pc_value), .reset_control_reg(rc), .stack_pointer_reg(sk), .irq(irq)
  );

  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // one-cycle cause, then pc and flag outputs
  task automatic fire(input logic [7:0] s, input logic [1:0] p, input logic r, input logic l,
                      input logic [20:0] pc, input logic [7:0] rce, input logic [7:0] ske);
    @(posedge clk);
    src <= s;
    pw  <= p;
    @(posedge clk);
    src <= '0;
    #1;
    chk("core_reset", r, core_reset);
    chk("pc_load", l, pc_load);
    chk("pc_value", pc, pc_value);
    @(posedge clk);
    #1;
    chk("reset_control_reg", rce, rc);
    chk("stack", ske, sk);
  endtask : fire

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= {a, d, 2'b10};
    @(posedge clk);
    req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= {a, 8'h00, 2'b01};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rdata", e, rdata);
  endtask : rd

  task automatic t_flags;
    chk("reset_control_reg", 8'h5c, rc);
    fire(8'h20, 0, 1, 1, 0, 8'h4c, 8'h00);
    fire(8'h40, 0, 1, 1, 0, 8'h5c, 8'h00);
    fire(8'h08, 0, 1, 1, 0, 8'h54, 8'h00);
    fire(8'h10, 1, 1, 1, 0, 8'h5c, 8'h00);
    fire(8'h10, 2, 1, 1, 0, 8'h58, 8'h00);
    fire(8'h10, 0, 1, 1, 0, 8'h58, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_wake;
    @(posedge clk);
    pc_now <= 21'h100;
    fire(8'h08, 3, 0, 1, 21'h102, 8'h50, 8'h00);
    fire(8'h40, 0, 1, 1, 0, 8'h5c, 8'h00);
    fire(8'h01, 2, 0, 1, 21'h102, 8'h58, 8'h00);
    @(posedge clk);
    gh <= 1;
    hi <= 1;
    fire(8'h01, 3, 0, 1, 21'h8, 8'h58, 8'h00);
    @(posedge clk);
    gh <= 0;
    gl <= 1;
    hi <= 0;
    fire(8'h01, 1, 0, 1, 21'h18, 8'h58, 8'h00);
    @(posedge clk);
    gl <= 0;
    $display("test wake done");
  endtask : t_wake

  task automatic t_stack;
    fire(8'h04, 0, 1, 1, 0, 8'h58, 8'h80);
    fire(8'h02, 0, 1, 1, 0, 8'h58, 8'hc0);
    fire(8'hc0, 0, 1, 1, 0, 8'h5c, 8'h00);
    @(posedge clk);
    sfe <= 0;
    fire(8'h02, 0, 0, 0, 0, 8'h5c, 8'h40);
    $display("test stack done");
  endtask : t_stack

  task automatic t_cfg;
    @(posedge clk);
    cfg <= 2'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("reset_control_reg", 8'h1c, rc);
    fire(8'h40, 0, 1, 1, 0, 8'h1c, 8'h40);
    @(posedge clk);
    cfg <= 2'h1;
    fire(8'h80, 0, 1, 1, 0, 8'h5c, 8'h00);
    $display("test config done");
  endtask : t_cfg

  task automatic t_regs;
    wr(rcsl_pkg::ADDR_IRQ_MASK, 8'h00);
    wr(rcsl_pkg::ADDR_IRQ_STAT, 8'hff);
    wr(rcsl_pkg::ADDR_GP, 8'h5a);
    fire(8'h10, 0, 1, 1, 0, 8'h5c, 8'h00);
    fire(8'h08, 3, 0, 1, 21'h102, 8'h50, 8'h00);
    rd(rcsl_pkg::ADDR_GP, 8'h5a);
    rd(rcsl_pkg::ADDR_PC_LO, 8'h02);
    rd(rcsl_pkg::ADDR_PC_MID, 8'h01);
    rd(rcsl_pkg::ADDR_PC_HI, 8'h00);
    rd(rcsl_pkg::ADDR_STACK, 8'h00);
    rd(rcsl_pkg::ADDR_IRQ_MASK, 8'h00);
    chk("irq", 0, irq);
    rd(rcsl_pkg::ADDR_IRQ_STAT, 8'h18);
    wr(rcsl_pkg::ADDR_IRQ_MASK, 8'h08);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 1, irq);
    wr(rcsl_pkg::ADDR_IRQ_STAT, 8'h18);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 0, irq);
    rd(4'hf, 8'h00);
    rd(rcsl_pkg::ADDR_RESET_CONTROL_REG, 8'h50);
    $display("test registers done");
  endtask : t_regs

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // reset, then the scenarios
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    #1;
    t_flags;
    t_wake;
    t_stack;
    t_cfg;
    t_regs;
    report_and_stop;
  end

  // hang guard
  initial
  begin
    #100000;
    errors++;
    report_and_stop;
  end
endmodule : rcsl_reset_cause_tb_top
